//--- logic/tpc_ch_if.sv
// Per-channel link between the shared counter core and a channel
`timescale 1ns/1ps
`default_nettype none
interface tpc_ch_if;
	logic        step;
	logic        wrap;
	logic [15:0] count_next;
	logic [15:0] cmp;
	logic [1:0]  action;
	logic        toggle_en;
	logic        full_duty;
	logic        active;
	logic        hit;
	logic        pin;

	modport core (
		output step, wrap, count_next, cmp, action,
		output toggle_en, full_duty, active,
		input  hit, pin
	);
	modport chan (
		input  step, wrap, count_next, cmp, action,
		input  toggle_en, full_duty, active,
		output hit, pin
	);
endinterface
`default_nettype wire

//--- logic/tpc_channel.sv
// One compare channel: match detect and output pin state
`timescale 1ns/1ps
`default_nettype none
module tpc_channel (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic reset_in,
	// Core link
	tpc_ch_if.chan    ch
);
	import tpc_pkg::*;

	logic pin_reg;

	// Match when the counter steps onto the compare value
	// width from compare
	assign ch.hit = ch.step & ch.active & (ch.count_next == ch.cmp);
	assign ch.pin = pin_reg;

	// Output state update on each counter step
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			pin_reg <= 1'b0;
		end else if (ch.step && ch.active) begin
			if (ch.full_duty && ch.toggle_en) begin
				pin_reg <= ~ch.action[0];
			end else if (ch.hit) begin
				case (ch.action)
					ACT_CLEAR:  pin_reg <= 1'b0;
					ACT_SET:    pin_reg <= 1'b1;
					ACT_TOGGLE: pin_reg <= ~pin_reg;
					default:    pin_reg <= pin_reg;
				endcase
			end else if (ch.wrap && ch.toggle_en) begin
				pin_reg <= ~pin_reg;
			end
		end
	end

	AST_WRAP_TOGGLE: assert property (@(posedge clk_in) disable iff (reset_in)
		(ch.wrap && ch.active && ch.toggle_en && !ch.full_duty && !ch.hit)
		|=> (pin_reg != $past(pin_reg)))
		else $error("pin did not toggle at wrap");

	AST_CMP_CLEAR: assert property (@(posedge clk_in) disable iff (reset_in)
		(ch.hit && ch.action == ACT_CLEAR && !(ch.full_duty && ch.toggle_en))
		|=> !pin_reg)
		else $error("pin not cleared on compare");

	AST_FULL_DUTY: assert property (@(posedge clk_in) disable iff (reset_in)
		(ch.step && ch.active && ch.full_duty && ch.toggle_en &&
		 ch.action == ACT_CLEAR) ##1 (!ch.step [*2]) |-> pin_reg)
		else $error("full duty output not high");

	AST_NO_WRAP_TOGGLE: assert property (@(posedge clk_in) disable iff (reset_in)
		(ch.wrap && !ch.toggle_en && !ch.hit) |=> $stable(pin_reg))
		else $error("pin toggled with wrap toggle off");

endmodule
`default_nettype wire

//--- logic/tpc_pkg.sv
// Shared constants for the timer PWM channel block
package tpc_pkg;

	// Bus, channel and counter geometry
	localparam int ADDR_W   = 12;
	localparam int DATA_W   = 32;
	localparam int NUM_CH   = 6;
	localparam int NUM_PAIR = 3;
	localparam int CNT_W    = 16;
	localparam int PRE_W    = 6;

	// Register byte addresses
	localparam logic [11:0] ADDR_TSC    = 12'h000;
	localparam logic [11:0] ADDR_PERIOD = 12'h004;
	localparam logic [11:0] ADDR_COUNT  = 12'h008;
	localparam logic [11:0] ADDR_CHCS   = 12'h010;
	localparam logic [11:0] ADDR_CMP    = 12'h040;
	localparam logic [11:0] CH_SPAN     = 12'h018;

	// Timer control and status field positions
	localparam int TSC_FLAG_BIT = 7;
	localparam int TSC_IE_BIT   = 6;
	localparam int TSC_HALT_BIT = 5;
	localparam int TSC_CLR_BIT  = 4;
	localparam int TSC_DIV_LSB  = 0;

	// Channel control and status field positions
	localparam int CH_FLAG_BIT   = 7;
	localparam int CH_IE_BIT     = 6;
	localparam int CH_PAIR_BIT   = 5;
	localparam int CH_SINGLE_BIT = 4;
	localparam int CH_ACT_LSB    = 2;
	localparam int CH_TOV_BIT    = 1;
	localparam int CH_MAX_BIT    = 0;

	// Clock divide and output action codes
	localparam logic [2:0] DIV_EXT    = 3'h7;
	localparam logic [1:0] ACT_NONE   = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR  = 2'h2;
	localparam logic [1:0] ACT_SET    = 2'h3;

	// Reset values
	localparam logic [15:0] PERIOD_RST = 16'hFFFF;
	localparam logic [15:0] CMP_RST    = 16'h0000;
	localparam logic [6:0]  CHCS_RST   = 7'h00;
	localparam logic [2:0]  DIV_RST    = 3'h0;
	localparam logic        HALT_RST   = 1'b1;

endpackage

//--- logic/tpc_timer.sv
// Shared counter, prescaler, APB registers and six PWM channels
`timescale 1ns/1ps
`default_nettype none
module tpc_timer (
	// Clock and reset
	input  wire logic                        clk_in,
	input  wire logic                        reset_in,
	// APB slave
	input  wire logic                        psel_in,
	input  wire logic                        penable_in,
	input  wire logic                        pwrite_in,
	input  wire logic [tpc_pkg::ADDR_W-1:0]  paddr_in,
	input  wire logic [tpc_pkg::DATA_W-1:0]  pwdata_in,
	output logic      [tpc_pkg::DATA_W-1:0]  prdata_out,
	output logic                             pready_out,
	output logic                             pslverr_out,
	// External timer clock pin
	input  wire logic                        ext_clock_pin_in,
	// Channel pins; 0, 2 and 4 are the pair output pins
	output logic      [tpc_pkg::NUM_CH-1:0]  channel_pin_out,
	output logic      [tpc_pkg::NUM_CH-1:0]  channel_oe_out
);
	import tpc_pkg::*;

	// Decode a per-channel register slot: {valid, index}
	function automatic logic [3:0] chan_slot(input logic [11:0] a,
			input logic [11:0] base);
		logic [11:0] off;
		off = a - base;
		chan_slot = {(off < CH_SPAN) && (off[1:0] == 2'h0), off[4:2]};
	endfunction

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] period_reg;
	logic [CNT_W-1:0] cmp_reg [NUM_CH];
	logic [6:0]       chcs_reg [NUM_CH];
	logic [PRE_W-1:0] presc_reg;
	logic [2:0]       div_reg;
	logic             halt_reg;
	logic             wrap_ie_reg;
	logic             wrap_flag_reg;
	logic             wrap_arm_reg;
	logic [NUM_CH-1:0] ch_flag_reg;
	logic [NUM_CH-1:0] ch_arm_reg;
	logic [NUM_PAIR-1:0] pair_sel_reg;
	logic [NUM_PAIR-1:0] pair_pend_reg;
	logic             ext_prev_reg;
	logic [DATA_W-1:0] prdata_reg;
	logic [DATA_W-1:0] rdata;
	logic [NUM_CH-1:0] ch_hit;
	logic [NUM_CH-1:0] ch_pin;
	logic [NUM_CH-1:0] ch_oe;
	logic [3:0]       cs_slot;
	logic [3:0]       cmp_slot;
	logic             hit_tsc;
	logic             hit_period;
	logic             hit_count;
	logic             mapped;
	logic             apb_wr;
	logic             apb_rd;
	logic             clear_wr;
	logic             tick;
	logic             step;
	logic             wrap;
	logic [CNT_W-1:0] count_next;
	logic [6:0]       div_onehot;
	logic [PRE_W-1:0] div_mask;

	// Address decode
	assign cs_slot    = chan_slot(paddr_in, ADDR_CHCS);
	assign cmp_slot   = chan_slot(paddr_in, ADDR_CMP);
	assign hit_tsc    = (paddr_in == ADDR_TSC);
	assign hit_period = (paddr_in == ADDR_PERIOD);
	assign hit_count  = (paddr_in == ADDR_COUNT);
	assign mapped     = hit_tsc | hit_period | hit_count | cs_slot[3] |
		cmp_slot[3];
	assign apb_wr     = psel_in & penable_in & pwrite_in & mapped;
	assign apb_rd     = psel_in & penable_in & ~pwrite_in & mapped;
	assign clear_wr   = apb_wr & hit_tsc & pwdata_in[TSC_CLR_BIT];

	// Bus answers: zero wait states, error on unmapped access
	assign pready_out  = 1'b1;
	assign pslverr_out = psel_in & penable_in & ~mapped;
	assign prdata_out  = prdata_reg;

	// Prescaler tap select; code 0 gives a mask of zero, a tick each clock
	// divide selection
	assign div_onehot = 7'h01 << div_reg;
	assign div_mask   = div_onehot[PRE_W-1:0] - 6'h01;
	always_comb begin
		if (div_reg == DIV_EXT) begin
			tick = ext_clock_pin_in & ~ext_prev_reg;
		end else begin
			tick = ((presc_reg & div_mask) == div_mask);
		end
	end

	// Counter step and wrap
	// wrap to zero
	assign step       = tick & ~halt_reg & ~clear_wr;
	assign wrap       = step & (count_reg == period_reg);
	assign count_next = wrap ? '0 : count_reg + 16'h0001;

	// External clock edge detector
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			ext_prev_reg <= 1'b0;
		end else begin
			ext_prev_reg <= ext_clock_pin_in;
		end
	end

	// Prescaler runs only while the counter runs
	// prescaler clear
	always_ff @(posedge clk_in) begin
		if (reset_in || clear_wr) begin
			presc_reg <= '0;
		end else if (!halt_reg) begin
			presc_reg <= presc_reg + 6'h01;
		end
	end

	// Shared modulo counter; period is limit plus one ticks
	// period from limit
	always_ff @(posedge clk_in) begin
		if (reset_in || clear_wr) begin
			count_reg <= '0;
		end else if (step) begin
			count_reg <= count_next;
		end
	end

	// Timer control fields
	// halt set by reset
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			halt_reg    <= HALT_RST;
			wrap_ie_reg <= 1'b0;
			div_reg     <= DIV_RST;
			period_reg  <= PERIOD_RST;
		end else if (apb_wr && hit_tsc) begin
			halt_reg    <= pwdata_in[TSC_HALT_BIT];
			wrap_ie_reg <= pwdata_in[TSC_IE_BIT];
			div_reg     <= pwdata_in[TSC_DIV_LSB +: 3];
		end else if (apb_wr && hit_period) begin
			period_reg  <= pwdata_in[CNT_W-1:0];
		end
	end

	// Wrap flag: read while set arms it, a zero written then clears it
	// wrap flag set
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			wrap_flag_reg <= 1'b0;
			wrap_arm_reg  <= 1'b0;
		end else if (wrap) begin
			wrap_flag_reg <= 1'b1;
			wrap_arm_reg  <= 1'b0;
		end else if (apb_rd && hit_tsc && wrap_flag_reg) begin
			wrap_arm_reg  <= 1'b1;
		end else if (apb_wr && hit_tsc) begin
			if (wrap_arm_reg && !pwdata_in[TSC_FLAG_BIT]) begin
				wrap_flag_reg <= 1'b0;
			end
			wrap_arm_reg  <= 1'b0;
		end
	end

	// Per-channel registers and flags
	genvar i;
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_chreg
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					cmp_reg[i] <= CMP_RST;
				end else if (apb_wr && cmp_slot == {1'b1, 3'(i)}) begin
					cmp_reg[i] <= pwdata_in[CNT_W-1:0];
				end
			end
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					chcs_reg[i] <= CHCS_RST;
				end else if (apb_wr && cs_slot == {1'b1, 3'(i)}) begin
					chcs_reg[i] <= pwdata_in[6:0];
				end
			end
			always_ff @(posedge clk_in) begin
				if (reset_in) begin
					ch_flag_reg[i] <= 1'b0;
					ch_arm_reg[i]  <= 1'b0;
				end else if (ch_hit[i]) begin
					ch_flag_reg[i] <= 1'b1;
					ch_arm_reg[i]  <= 1'b0;
				end else if (apb_rd && cs_slot == {1'b1, 3'(i)} &&
						ch_flag_reg[i]) begin
					ch_arm_reg[i]  <= 1'b1;
				end else if (apb_wr && cs_slot == {1'b1, 3'(i)}) begin
					if (ch_arm_reg[i] && !pwdata_in[CH_FLAG_BIT]) begin
						ch_flag_reg[i] <= 1'b0;
					end
					ch_arm_reg[i]  <= 1'b0;
				end
			end
		end
	endgenerate

	// Pair set tracking: last written set takes over at the next wrap
	genvar p;
	generate
		for (p = 0; p < NUM_PAIR; p++) begin : g_pair
			always_ff @(posedge clk_in) begin
				if (reset_in || !chcs_reg[2*p][CH_PAIR_BIT]) begin
					pair_pend_reg[p] <= 1'b0;
					pair_sel_reg[p]  <= 1'b0;
				end else begin
					if (apb_wr && cmp_slot == {1'b1, 3'(2*p)}) begin
						pair_pend_reg[p] <= 1'b0;
					end else if (apb_wr && cmp_slot == {1'b1, 3'(2*p+1)}) begin
						pair_pend_reg[p] <= 1'b1;
					end
					if (wrap) begin
						pair_sel_reg[p] <= pair_pend_reg[p];
					end
				end
			end
		end
	endgenerate

	// Channel instances and their configuration
	tpc_ch_if ch_if [NUM_CH] ();
	generate
		for (i = 0; i < NUM_CH; i++) begin : g_ch
			logic linked;
			logic freed;
			if (i % 2 == 0) begin : g_even
				assign linked = chcs_reg[i][CH_PAIR_BIT];
				assign freed  = 1'b0;
				assign ch_if[i].cmp = (linked && pair_sel_reg[i/2]) ?
					cmp_reg[i+1] : cmp_reg[i];
			end else begin : g_odd
				assign linked = 1'b0;
				assign freed  = chcs_reg[i-1][CH_PAIR_BIT];
				assign ch_if[i].cmp = cmp_reg[i];
			end
			assign ch_if[i].step       = step;
			assign ch_if[i].wrap       = wrap;
			assign ch_if[i].count_next = count_next;
			assign ch_if[i].action     = chcs_reg[i][CH_ACT_LSB +: 2];
			assign ch_if[i].toggle_en  = chcs_reg[i][CH_TOV_BIT];
			assign ch_if[i].full_duty  = chcs_reg[i][CH_MAX_BIT];
			assign ch_if[i].active     = ~freed &
				(linked | chcs_reg[i][CH_SINGLE_BIT]);
			assign ch_hit[i] = ch_if[i].hit;
			assign ch_pin[i] = ch_if[i].pin;
			assign ch_oe[i]  = ch_if[i].active &
				(chcs_reg[i][CH_ACT_LSB +: 2] != ACT_NONE);
			tpc_channel u_ch (
				.clk_in   (clk_in),
				.reset_in (reset_in),
				.ch       (ch_if[i])
			);
		end
	endgenerate

	assign channel_pin_out = ch_pin;
	assign channel_oe_out  = ch_oe;

	// Read data mux; the clear bit always reads zero
	always_comb begin
		rdata = '0;
		if (hit_tsc) begin
			rdata[TSC_FLAG_BIT]         = wrap_flag_reg;
			rdata[TSC_IE_BIT]           = wrap_ie_reg;
			rdata[TSC_HALT_BIT]         = halt_reg;
			rdata[TSC_DIV_LSB +: 3]     = div_reg;
		end else if (hit_period) begin
			rdata[CNT_W-1:0] = period_reg;
		end else if (hit_count) begin
			rdata[CNT_W-1:0] = count_reg;
		end else if (cs_slot[3]) begin
			rdata[CH_FLAG_BIT] = ch_flag_reg[cs_slot[2:0]];
			rdata[6:0]         = chcs_reg[cs_slot[2:0]];
		end else if (cmp_slot[3]) begin
			rdata[CNT_W-1:0] = cmp_reg[cmp_slot[2:0]];
		end
	end

	// Read data is captured in the setup cycle
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			prdata_reg <= '0;
		end else if (psel_in && !penable_in) begin
			prdata_reg <= rdata;
		end
	end

	AST_WRAP_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
		(step && count_reg == period_reg) |=> (count_reg == 16'h0000))
		else $error("counter did not return to zero");

	AST_WRAP_FLAG: assert property (@(posedge clk_in) disable iff (reset_in)
		(step && count_reg == period_reg) |=> wrap_flag_reg)
		else $error("wrap flag not set");

	AST_HALT_HOLD: assert property (@(posedge clk_in) disable iff (reset_in)
		(halt_reg && !clear_wr) |=> $stable(count_reg))
		else $error("counter moved while halted");

	AST_CLEAR_ZERO: assert property (@(posedge clk_in) disable iff (reset_in)
		clear_wr |=> (count_reg == 16'h0000 && presc_reg == 6'h00 &&
		rdata[TSC_CLR_BIT] == 1'b0))
		else $error("clear did not zero counter");

	AST_DIV1_STEP: assert property (@(posedge clk_in) disable iff (reset_in)
		(div_reg == 3'h0 && !halt_reg && !clear_wr && count_reg != period_reg)
		|=> (count_reg == $past(count_reg) + 16'h0001))
		else $error("divide by one did not count each clock");

	AST_BUF_SWAP: assert property (@(posedge clk_in) disable iff (reset_in)
		(wrap && chcs_reg[0][CH_PAIR_BIT]) |=>
		(!chcs_reg[0][CH_PAIR_BIT] ||
		 pair_sel_reg[0] == $past(pair_pend_reg[0])))
		else $error("pair set did not swap at wrap");

	AST_ODD_FREE: assert property (@(posedge clk_in) disable iff (reset_in)
		chcs_reg[0][CH_PAIR_BIT] |-> (!channel_oe_out[1] && !ch_hit[1]))
		else $error("odd channel active while linked");

	AST_CMP_FLAG: assert property (@(posedge clk_in) disable iff (reset_in)
		ch_hit[0] |=> ch_flag_reg[0])
		else $error("compare flag not set");

endmodule
`default_nettype wire

//--- sim/tb_tpc_timer.sv
// Self-checking bench for the timer PWM channel block
`timescale 1ns/1ps
`default_nettype none
module tb_tpc_timer;
	import tpc_pkg::*;

	// One table row: channel setup and the pin duty it should give
	typedef struct {
		int          ch;
		logic [15:0] per;
		logic [15:0] cv;
		logic [7:0]  ctl;
		logic [2:0]  dv;
		int          hi;
		logic [5:0]  oe;
	} tpc_row_t;

	logic        clk_in;
	logic        reset_in;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [5:0]  pin;
	logic [5:0]  oe;
	logic [2:0]  ext_cnt = 3'h0;
	int          n_mismatch;
	int          n_compared;
	logic [31:0] rd;
	logic        er;
	int          hi;
	int          k;

	// Ordinary cases; no row uses toggle on compare
	// toggle action avoided
	tpc_row_t rows [12] = '{
		'{0, 16'h00FF, 16'h0080, 8'h1A, 3'h0, 128, 6'h01},
		'{1, 16'h000F, 16'h0004, 8'h1A, 3'h1, 8, 6'h02},
		'{2, 16'h000F, 16'h0004, 8'h1A, 3'h2, 16, 6'h04},
		'{3, 16'h000F, 16'h0004, 8'h1A, 3'h3, 32, 6'h08},
		'{4, 16'h000F, 16'h0004, 8'h1A, 3'h4, 64, 6'h10},
		'{5, 16'h000F, 16'h0004, 8'h1A, 3'h5, 128, 6'h20},
		'{0, 16'h000F, 16'h0004, 8'h1A, 3'h6, 256, 6'h01},
		'{1, 16'h000F, 16'h0004, 8'h1A, 3'h7, 32, 6'h02},
		'{2, 16'h00FF, 16'h0040, 8'h1E, 3'h0, 192, 6'h04},
		'{3, 16'h00FF, 16'h0080, 8'h18, 3'h0, 0, 6'h08},
		'{4, 16'h000F, 16'h0004, 8'h1B, 3'h2, 64, 6'h10},
		'{0, 16'h00FF, 16'h0020, 8'h2A, 3'h0, 32, 6'h01}
	};

	tpc_timer tpc_timer_inst (
		.clk_in           (clk_in),
		.reset_in         (reset_in),
		.psel_in          (psel),
		.penable_in       (penable),
		.pwrite_in        (pwrite),
		.paddr_in         (paddr),
		.pwdata_in        (pwdata),
		.prdata_out       (prdata),
		.pready_out       (pready),
		.pslverr_out      (pslverr),
		.ext_clock_pin_in (ext_cnt[2]),
		.channel_pin_out  (pin),
		.channel_oe_out   (oe)
	);

	// 40 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	// External timer clock: one rising edge every 8 bus clocks
	always @(posedge clk_in) begin
		ext_cnt <= ext_cnt + 3'h1;
	end

	// Verdict and end of run
	task automatic report_and_stop();
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Compare a design value
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// Compare a counted pin duty
	task automatic chk_cnt(input int got, input int exp);
		n_compared++;
		if (got != exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
		end
	endtask

	// One APB transfer; read data and error taken at the ready edge
	task automatic apb(input logic w, input logic [11:0] a,
			input logic [31:0] d);
		int i;
		@(posedge clk_in);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk_in);
			if (pready === 1'b1) break;
		end
		if (i == 40) begin
			n_mismatch++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Count high cycles of one pin over n clocks, sampled mid-cycle
	task automatic measure(input int ch, input int n);
		hi = 0;
		repeat (n) begin
			@(negedge clk_in);
			if (pin[ch] === 1'b1) hi++;
		end
	endtask

	// Full setup of one channel, then settle and measure one period
	// halt, clear, period, width, mode, run
	task automatic run_row(input tpc_row_t r);
		int win;
		apb(1'b1, ADDR_TSC, 32'h30);
		apb(1'b1, ADDR_PERIOD, {16'h0, r.per});
		apb(1'b1, ADDR_CMP + 12'(4 * r.ch), {16'h0, r.cv});
		apb(1'b1, ADDR_CHCS + 12'(4 * r.ch), {24'h0, r.ctl});
		apb(1'b1, ADDR_TSC, {29'h0, r.dv});
		win = (int'(r.per) + 1) << ((r.dv == 3'h7) ? 3 : int'(r.dv));
		repeat (win) @(posedge clk_in);
		measure(r.ch, win);
		chk_cnt(hi, r.hi);
		chk_cnt(hi, r.hi);
		chk_reg({26'h0, oe}, {26'h0, r.oe});
		apb(1'b1, ADDR_CHCS + 12'(4 * r.ch), 32'h0);
	endtask

	// Main sequence
	initial begin
		psel       = 1'b0;
		penable    = 1'b0;
		pwrite     = 1'b0;
		paddr      = 12'h000;
		pwdata     = 32'h0;
		reset_in   = 1'b1;
		n_mismatch = 0;
		n_compared = 0;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		// Reset values
		chk_reg({26'h0, pin}, 32'h0);
		chk_reg({26'h0, oe}, 32'h0);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk_reg(rd, 32'h20);
		apb(1'b0, ADDR_PERIOD, 32'h0);
		chk_reg(rd, 32'hFFFF);
		apb(1'b0, ADDR_CMP + 12'h014, 32'h0);
		chk_reg(rd, 32'h0);
		apb(1'b0, ADDR_CHCS + 12'h00C, 32'h0);
		chk_reg(rd, 32'h0);
		for (k = 0; k < 12; k++) begin
			run_row(rows[k]);
		end
		// Linked pair with both mode bits set; odd control ignored
		apb(1'b1, ADDR_TSC, 32'h30);
		apb(1'b1, ADDR_CMP, 32'h20);
		apb(1'b1, ADDR_CHCS, 32'h3A);
		apb(1'b1, ADDR_CHCS + 12'h004, 32'h1A);
		apb(1'b1, ADDR_TSC, 32'h0);
		repeat (256) @(posedge clk_in);
		measure(0, 256);
		chk_cnt(hi, 32);
		chk_reg({26'h0, oe}, 32'h01);
		// Inactive odd set written; takes over at the next wrap
		// only the idle set written
		apb(1'b1, ADDR_CMP + 12'h004, 32'h60);
		repeat (512) @(posedge clk_in);
		measure(0, 256);
		chk_cnt(hi, 96);
		apb(1'b1, ADDR_CMP, 32'h10);
		repeat (512) @(posedge clk_in);
		measure(0, 256);
		chk_cnt(hi, 16);
		// Back to single compare; a direct write acts at once
		// longer width given two periods to settle
		apb(1'b1, ADDR_CHCS + 12'h004, 32'h0);
		apb(1'b1, ADDR_CHCS, 32'h1A);
		apb(1'b1, ADDR_CMP, 32'h60);
		repeat (512) @(posedge clk_in);
		measure(0, 256);
		chk_cnt(hi, 96);
		// Flags, halt and counter clear
		apb(1'b0, ADDR_CHCS, 32'h0);
		chk_reg(rd & 32'h80, 32'h80);
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk_reg(rd & 32'h80, 32'h80);
		apb(1'b1, ADDR_TSC, 32'h20);
		apb(1'b0, ADDR_COUNT, 32'h0);
		hi = int'(rd);
		repeat (20) @(posedge clk_in);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk_reg(rd, 32'(hi));
		apb(1'b0, ADDR_TSC, 32'h0);
		chk_reg(rd, 32'h20);
		apb(1'b1, ADDR_TSC, 32'h30);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk_reg(rd, 32'h0);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk_reg(rd, 32'h20);
		// Counter is read only; unmapped place reports an error
		apb(1'b1, ADDR_COUNT, 32'h55);
		apb(1'b0, ADDR_COUNT, 32'h0);
		chk_reg(rd, 32'h0);
		chk_reg({31'h0, er}, 32'h0);
		apb(1'b0, 12'hFFC, 32'h0);
		chk_reg({31'h0, er}, 32'h1);
		// Reset in mid-run
		apb(1'b1, ADDR_TSC, 32'h0);
		repeat (100) @(posedge clk_in);
		reset_in <= 1'b1;
		repeat (8) @(posedge clk_in);
		reset_in <= 1'b0;
		@(posedge clk_in);
		chk_reg({20'h0, pin, oe}, 32'h0);
		apb(1'b0, ADDR_TSC, 32'h0);
		chk_reg(rd, 32'h20);
		report_and_stop();
	end
endmodule
`default_nettype wire
